// ---- design/flash_protect_erase_logic.sv ----
// Flash protection, lock, security and erase-pin sequencer with AHB-Lite registers
// Functional notes
// - Erase pin is filtered by a debouncer ticking at the slow clock rate
// - Erase pin high shorter than 100 ms never starts an erase
// - Erase pin high longer than 220 ms performs a full array erase
// - Pin erase leaves every array bit and nonvolatile cell reading one
// - Pin is erase input after reset; in I/O mode it never erases
// - Lock regions are 64 pages of 256 bytes; eight lock bits
// - Program or erase on a locked region aborts and raises interrupt
// - Set-lock command sets region bit; clear-lock command clears it
// - Qualified erase pin clears all lock bits
// - Security bit blocks all debug and programming port access
// - Security bit only set by command; no command clears it
// - Security clears only after pin erase completes or on reset; access then allowed
// - Calibration bits are fixed and untouched by pin erase
// - Fixed 128-bit unique identifier survives pin erase
// - Array is one plane of 512 pages of 256 bytes
// - 128-byte write buffer filled over 32-bit interface
// - Array reads fetch 128 bits or 64 bits, selectable
// - Descriptor command reports sizes and regions to software
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
module flash_protect_erase_logic #(
  parameter int           SLOW_DIV    = flash_protect_pkg::SLOW_DIV_CYC,
  parameter int           ERASE_COUNT = flash_protect_pkg::ERASE_TICKS,
  parameter logic [127:0] UNIQUE_ID   = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978,
  parameter logic [31:0]  CALIB_BITS  = 32'h0000_5A5A
) (
  input  wire  logic        CORE_CLK_I,   // System clock, 200 MHz
  input  wire  logic        RSTN_I,       // Synchronous reset, active low
  input  wire  logic        HSEL_I,       // AHB slave select
  input  wire  logic [31:0] HADDR_I,      // AHB address
  input  wire  logic [1:0]  HTRANS_I,     // AHB transfer type
  input  wire  logic        HWRITE_I,     // AHB write
  input  wire  logic [2:0]  HSIZE_I,      // AHB size, words only
  input  wire  logic [31:0] HWDATA_I,     // AHB write data
  input  wire  logic        HREADY_I,     // AHB bus ready
  output logic [31:0]       HRDATA_O,     // AHB read data
  output logic              HREADYOUT_O,  // AHB slave ready
  output logic              HRESP_O,      // AHB response, always OKAY
  input  wire  logic        ERASE_PIN_I,  // External erase pin
  output logic              IRQ_O,        // Lock violation interrupt
  output logic              DEBUG_LOCK_O  // Blocks debug and programming ports
);
  import flash_protect_pkg::*;

  // Cycle-accurate ticks are one enable pulse per slow clock period
  typedef struct packed {
    logic                  ready;
    logic [31:0]           rdata;
    logic                  pend;
    logic                  pwrite;
    logic [17:0]           paddr;
    logic                  fetching;
    logic [3:0]            wait_cnt;
    logic [127:0]          line;
    logic [13:0]           line_tag;
    logic                  line_wide;
    logic                  line_ok;
    logic                  wide_read;
    logic [3:0]            wait_states;
    logic                  pin_io;
    seq_type               seq;
    logic [14:0]           seq_addr;
    logic [14:0]           seq_end;
    logic [LOCK_BITS-1:0]  locks;
    logic [GPNV_BITS-1:0]  gpnv_cells;
    logic                  cmd_error;
    logic                  lock_error;
    logic [2:0]            desc_idx;
    logic [15:0]           div_cnt;
    logic                  tick;
    logic [15:0]           pin_cnt;
    logic                  pin_qual;
    logic                  pin_wait_low;
    logic [WBUF_WORDS-1:0][31:0] wbuf;
    logic                  irq;
    logic                  dbg_lock;
  } state_type;

  state_type   st;
  state_type   next_st;
  logic [31:0] mem [0:WORDS-1];
  logic        mem_we;
  logic [31:0] mem_wdata;
  logic [14:0] waddr;
  logic        line_hit;
  logic [14:0] wide_base;
  logic [14:0] narrow_base;

  function automatic logic [2:0] region_of(input logic [14:0] word_addr);
    return word_addr[14:12];
  endfunction : region_of

  assign waddr       = st.paddr[16:2];
  assign wide_base   = {waddr[14:2], 2'b00};
  assign narrow_base = {waddr[14:1], 1'b0};
  assign line_hit    = st.line_ok && (st.line_wide == st.wide_read) &&
                       (st.wide_read ? (st.line_tag[13:1] == waddr[14:2])
                                     : (st.line_tag == waddr[14:1]));
  assign mem_we      = (st.seq == S_PROG) || (st.seq == S_ERASE) || (st.seq == S_PIN_ERASE);
  // Programming can only clear bits, so the buffer is ANDed into the cell
  assign mem_wdata   = (st.seq == S_PROG) ? (mem[st.seq_addr] & st.wbuf[st.seq_addr[4:0]])
                                          : 32'hFFFF_FFFF;

  always_ff @(posedge CORE_CLK_I) begin
    if (mem_we) begin
      mem[st.seq_addr] <= mem_wdata;
    end
  end

  always_comb begin
    logic [7:0] code;
    logic [9:0] arg;
    code = HWDATA_I[7:0];
    arg  = HWDATA_I[CMD_ARG_LSB+9:CMD_ARG_LSB];
    next_st      = st;
    next_st.tick = 1'b0;

    if (st.div_cnt == 16'(SLOW_DIV - 1)) begin
      next_st.div_cnt = 16'h0000;
      next_st.tick    = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 16'h0001;
    end

    if (st.pin_io || !ERASE_PIN_I) begin
      next_st.pin_cnt      = 16'h0000;
      next_st.pin_wait_low = 1'b0;
    end else if (st.tick && !st.pin_wait_low) begin
      if (st.pin_cnt == 16'(ERASE_COUNT - 1)) begin
        next_st.pin_qual     = 1'b1;
        next_st.pin_wait_low = 1'b1;
        next_st.pin_cnt      = 16'h0000;
      end else begin
        next_st.pin_cnt = st.pin_cnt + 16'h0001;
      end
    end

    if (st.pend) begin
      if (st.pwrite) begin
        next_st.pend  = 1'b0;
        next_st.ready = 1'b1;
        if (st.paddr[11:7] == WBUF_BASE) begin
          next_st.wbuf[st.paddr[6:2]] = HWDATA_I;
        end else if (st.paddr[11:0] == REG_CONFIG) begin
          next_st.wide_read   = HWDATA_I[CF_WIDE];
          next_st.wait_states = HWDATA_I[CF_WS_LSB+3:CF_WS_LSB];
          next_st.pin_io      = HWDATA_I[CF_PIN_IO];
        end else if (st.paddr[11:0] == REG_CMD) begin
          if (st.seq != S_IDLE || st.pin_qual) begin
            next_st.cmd_error = 1'b1;
          end else begin
            case (code)
              CMD_PROG: begin
                if (st.locks[arg[9:7]]) begin
                  next_st.lock_error = 1'b1;
                end else begin
                  next_st.seq      = S_PROG;
                  next_st.seq_addr = {arg, 5'h00};
                  next_st.seq_end  = {arg, 5'h1F};
                end
              end
              CMD_ERASE_PG: begin
                if (st.locks[region_of({arg[8:0], 6'h00})]) begin
                  next_st.lock_error = 1'b1;
                end else begin
                  next_st.seq      = S_ERASE;
                  next_st.seq_addr = {arg[8:0], 6'h00};
                  next_st.seq_end  = {arg[8:0], 6'h3F};
                end
              end
              CMD_SET_LOCK: begin
                next_st.locks[arg[2:0]] = 1'b1;
              end
              CMD_CLR_LOCK: begin
                next_st.locks[arg[2:0]] = 1'b0;
              end
              CMD_SET_GPNV: begin
                next_st.gpnv_cells[arg[0]] = 1'b0;
              end
              CMD_CLR_GPNV: begin
                if (arg[0] == 1'b0) begin
                  next_st.cmd_error = 1'b1;
                end else begin
                  next_st.gpnv_cells[1] = 1'b1;
                end
              end
              CMD_GET_DESC: begin
                next_st.desc_idx = 3'h1;
              end
              default: begin
                next_st.cmd_error = 1'b1;
              end
            endcase
          end
        end
      end else if (!st.paddr[17]) begin
        next_st.pend  = 1'b0;
        next_st.ready = 1'b1;
        if (st.paddr[11:7] == WBUF_BASE) begin
          next_st.rdata = st.wbuf[st.paddr[6:2]];
        end else begin
          case (st.paddr[11:0])
            REG_STATUS: begin
              next_st.rdata                = 32'h0000_0000;
              next_st.rdata[ST_READY]      = (st.seq == S_IDLE);
              next_st.rdata[ST_CMDERR]     = st.cmd_error;
              next_st.rdata[ST_LOCKERR]    = st.lock_error;
              next_st.rdata[ST_SECURE]     = ~st.gpnv_cells[0];
              next_st.rdata[ST_PINERA]     = st.pin_qual;
              next_st.cmd_error            = 1'b0;
              next_st.lock_error           = 1'b0;
            end
            REG_CONFIG: begin
              next_st.rdata                       = 32'h0000_0000;
              next_st.rdata[CF_WIDE]              = st.wide_read;
              next_st.rdata[CF_WS_LSB+3:CF_WS_LSB] = st.wait_states;
              next_st.rdata[CF_PIN_IO]            = st.pin_io;
            end
            REG_RESULT: begin
              case (st.desc_idx)
                3'h1:    next_st.rdata = DESC_ARRAY_BYTES;
                3'h2:    next_st.rdata = DESC_PAGE_BYTES;
                3'h3:    next_st.rdata = DESC_PAGES;
                3'h4:    next_st.rdata = DESC_LOCK_COUNT;
                3'h5:    next_st.rdata = DESC_LOCK_BYTES;
                3'h6:    next_st.rdata = DESC_WBUF_BYTES;
                default: next_st.rdata = 32'h0000_0000;
              endcase
              next_st.desc_idx = (st.desc_idx == 3'h0 || st.desc_idx == 3'h6) ? 3'h0
                                 : st.desc_idx + 3'h1;
            end
            REG_LOCKS: next_st.rdata = {24'h00_0000, st.locks};
            REG_GPNV:  next_st.rdata = {30'h0000_0000, st.gpnv_cells};
            REG_UID0:  next_st.rdata = UNIQUE_ID[31:0];
            REG_UID1:  next_st.rdata = UNIQUE_ID[63:32];
            REG_UID2:  next_st.rdata = UNIQUE_ID[95:64];
            REG_UID3:  next_st.rdata = UNIQUE_ID[127:96];
            REG_CALIB: next_st.rdata = CALIB_BITS;
            default:   next_st.rdata = 32'h0000_0000;
          endcase
        end
      end else if (line_hit) begin
        next_st.pend  = 1'b0;
        next_st.ready = 1'b1;
        next_st.rdata = st.wide_read ? st.line[32*waddr[1:0] +: 32]
                                     : st.line[32*waddr[0] +: 32];
      end else if (st.seq == S_IDLE) begin
        // Reads stall while the sequencer owns the array
        if (!st.fetching) begin
          next_st.fetching = 1'b1;
          next_st.wait_cnt = st.wait_states;
        end else if (st.wait_cnt == 4'h0) begin
          next_st.fetching  = 1'b0;
          next_st.line_ok   = 1'b1;
          next_st.line_wide = st.wide_read;
          next_st.line_tag  = waddr[14:1];
          if (st.wide_read) begin
            next_st.line = {mem[wide_base + 15'd3], mem[wide_base + 15'd2],
                            mem[wide_base + 15'd1], mem[wide_base]};
          end else begin
            next_st.line = {64'h0, mem[narrow_base + 15'd1], mem[narrow_base]};
          end
        end else begin
          next_st.wait_cnt = st.wait_cnt - 4'h1;
        end
      end
    end else if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
      next_st.pend   = 1'b1;
      next_st.pwrite = HWRITE_I;
      next_st.paddr  = HADDR_I[17:0];
      next_st.ready  = 1'b0;
    end

    case (st.seq)
      S_IDLE: begin
        if (st.pin_qual) begin
          next_st.seq      = S_PIN_ERASE;
          next_st.seq_addr = 15'h0000;
          next_st.seq_end  = 15'(WORDS - 1);
        end
      end
      S_PROG, S_ERASE, S_PIN_ERASE: begin
        next_st.line_ok  = 1'b0;
        next_st.seq_addr = st.seq_addr + 15'h0001;
        if (st.seq_addr == st.seq_end) begin
          next_st.seq = (st.seq == S_PIN_ERASE) ? S_PIN_CLEAR : S_IDLE;
        end
      end
      S_PIN_CLEAR: begin
        next_st.locks      = '0;
        next_st.gpnv_cells = '1;
        next_st.pin_qual   = 1'b0;
        next_st.seq        = S_IDLE;
      end
      default: begin
        next_st.seq = S_IDLE;
      end
    endcase

    next_st.irq      = next_st.lock_error;
    next_st.dbg_lock = ~next_st.gpnv_cells[0];
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      st             <= '0;
      st.ready       <= 1'b1;
      st.seq         <= S_IDLE;
      st.wide_read   <= RST_WIDE;
      st.wait_states <= RST_WS;
      st.pin_io      <= RST_PINIO;
      st.gpnv_cells  <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign HRDATA_O     = st.rdata;
  assign HREADYOUT_O  = st.ready;
  assign HRESP_O      = 1'b0;
  assign IRQ_O        = st.irq;
  assign DEBUG_LOCK_O = st.dbg_lock;

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  pin_qualify_a: assert property ((st.tick && ERASE_PIN_I && !st.pin_io && !st.pin_wait_low &&
                      st.pin_cnt == 16'(ERASE_COUNT - 1)) |=> st.pin_qual)
    else $error("Held erase pin did not qualify");
  pin_short_a: assert property ((!st.pin_qual && st.pin_cnt != 16'(ERASE_COUNT - 1))
                      |=> !st.pin_qual)
    else $error("Erase qualified before the debounce count");
  pin_io_a: assert property ((st.pin_io && !st.pin_qual) |=> !st.pin_qual)
    else $error("Erase qualified while pin is in I/O mode");
  erase_ones_a: assert property ((st.seq == S_PIN_ERASE) |-> (mem_we && mem_wdata == 32'hFFFF_FFFF))
    else $error("Pin erase wrote a word other than all ones");
  clear_after_a: assert property ((st.seq == S_PIN_CLEAR) |-> $past(st.seq) == S_PIN_ERASE
                      ##1 (st.locks == '0 && st.gpnv_cells == '1 && st.seq == S_IDLE))
    else $error("Protection released out of order");
  lock_abort_a: assert property ((st.pend && st.pwrite && st.paddr[11:0] == REG_CMD && !st.paddr[17] &&
                      st.seq == S_IDLE && !st.pin_qual && HWDATA_I[7:0] == CMD_PROG &&
                      st.locks[HWDATA_I[17:15]]) |=> (st.lock_error && st.seq == S_IDLE) ##1 IRQ_O)
    else $error("Locked program command was not aborted");
  set_lock_a: assert property ((st.pend && st.pwrite && st.paddr[11:0] == REG_CMD && !st.paddr[17] &&
                      st.seq == S_IDLE && !st.pin_qual && HWDATA_I[7:0] == CMD_SET_LOCK)
                      |=> st.locks[$past(HWDATA_I[10:8])])
    else $error("Set-lock command did not set the bit");
  secure_hold_a: assert property ((!st.gpnv_cells[0] && st.seq != S_PIN_CLEAR)
                      |=> !st.gpnv_cells[0])
    else $error("Security bit cleared outside the pin erase");
  debug_block_a: assert property ($fell(st.gpnv_cells[0]) |=> DEBUG_LOCK_O [*2])
    else $error("Debug port not blocked while secure");
  debug_free_a: assert property ((st.seq == S_PIN_CLEAR) |=> ##1 !DEBUG_LOCK_O)
    else $error("Debug port still blocked after pin erase");

endmodule : flash_protect_erase_logic

// ---- design/flash_protect_pkg.sv ----
// Constants and types shared by the flash protection and erase block
package flash_protect_pkg;

  // Timing
  localparam int CLK_HZ       = 200_000_000;
  localparam int SLOW_HZ      = 32_768;
  localparam int SLOW_DIV_CYC = CLK_HZ / SLOW_HZ;
  localparam int ERASE_MS     = 160;
  localparam int ERASE_TICKS  = (ERASE_MS * SLOW_HZ + 999) / 1000;

  // Array organisation
  localparam int WORDS        = 32_768;
  localparam int LOCK_BITS    = 8;
  localparam int GPNV_BITS    = 2;
  localparam int WBUF_WORDS   = 32;

  // Register byte offsets
  localparam logic [11:0] REG_CMD    = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_CONFIG = 12'h008;
  localparam logic [11:0] REG_RESULT = 12'h00C;
  localparam logic [11:0] REG_LOCKS  = 12'h010;
  localparam logic [11:0] REG_GPNV   = 12'h014;
  localparam logic [11:0] REG_UID0   = 12'h018;
  localparam logic [11:0] REG_UID1   = 12'h01C;
  localparam logic [11:0] REG_UID2   = 12'h020;
  localparam logic [11:0] REG_UID3   = 12'h024;
  localparam logic [11:0] REG_CALIB  = 12'h028;
  localparam logic [4:0]  WBUF_BASE  = 5'h01;

  // Field positions
  localparam int ST_READY   = 0;
  localparam int ST_CMDERR  = 1;
  localparam int ST_LOCKERR = 2;
  localparam int ST_SECURE  = 3;
  localparam int ST_PINERA  = 4;
  localparam int CF_WIDE    = 0;
  localparam int CF_WS_LSB  = 8;
  localparam int CF_PIN_IO  = 12;
  localparam int CMD_ARG_LSB = 8;

  // Reset values
  localparam logic       RST_WIDE  = 1'b1;
  localparam logic [3:0] RST_WS    = 4'hF;
  localparam logic       RST_PINIO = 1'b0;

  // Commands
  localparam logic [7:0] CMD_PROG     = 8'h01;
  localparam logic [7:0] CMD_ERASE_PG = 8'h02;
  localparam logic [7:0] CMD_SET_LOCK = 8'h03;
  localparam logic [7:0] CMD_CLR_LOCK = 8'h04;
  localparam logic [7:0] CMD_SET_GPNV = 8'h05;
  localparam logic [7:0] CMD_CLR_GPNV = 8'h06;
  localparam logic [7:0] CMD_GET_DESC = 8'h07;

  // Descriptor words
  localparam logic [31:0] DESC_ARRAY_BYTES = 32'h0002_0000;
  localparam logic [31:0] DESC_PAGE_BYTES  = 32'h0000_0100;
  localparam logic [31:0] DESC_PAGES       = 32'h0000_0200;
  localparam logic [31:0] DESC_LOCK_COUNT  = 32'h0000_0008;
  localparam logic [31:0] DESC_LOCK_BYTES  = 32'h0000_4000;
  localparam logic [31:0] DESC_WBUF_BYTES  = 32'h0000_0080;

  typedef enum logic [2:0] {S_IDLE, S_PROG, S_ERASE, S_PIN_ERASE, S_PIN_CLEAR} seq_type;

endpackage : flash_protect_pkg

// ---- tb/erase_pin_model.sv ----
// Behavioural driver of the external erase pin
`timescale 1ns/10ps
module erase_pin_model (
  input  wire logic clk_i,  // System clock
  output logic      pin_o   // Erase pin level
);
  // Low from time zero, so startup never erases
  initial pin_o = 1'b0;

  // Holds the pin high for a whole number of cycles, then releases it low
  task automatic drive(input int cycles);
    @(posedge clk_i);
    pin_o <= 1'b1;
    repeat (cycles) @(posedge clk_i);
    pin_o <= 1'b0;
  endtask : drive
endmodule : erase_pin_model

// ---- tb/flash_protect_erase_logic_tb.sv ----
// Self-checking bench for the flash protection and erase block
`timescale 1ns/10ps
module flash_protect_erase_logic_tb;
  import flash_protect_pkg::*;
  // Identifier and calibration values are arbitrary
  localparam logic [127:0] UID_VAL = 128'hC0DE_0001_C0DE_0002_C0DE_0003_C0DE_0004;
  localparam logic [31:0]  CAL_VAL = 32'h0000_3C96;
  localparam logic [31:0]  DESC_EXP [7] = '{DESC_ARRAY_BYTES, DESC_PAGE_BYTES, DESC_PAGES,
    DESC_LOCK_COUNT, DESC_LOCK_BYTES, DESC_WBUF_BYTES, 32'h0000_0000};
  localparam logic [7:0]   LOCKED_CMDS [2] = '{CMD_ERASE_PG, CMD_PROG};
  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hresp;
  logic [31:0] hrdata;
  logic        hready;
  logic        pin;
  logic        irq;
  logic        dbg_lock;
  logic [31:0] rd;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  int          n;

  always #2.5 clk = ~clk;

  // Short debounce counts keep the pin scenarios brief
  flash_protect_erase_logic #(.SLOW_DIV(4), .ERASE_COUNT(5), .UNIQUE_ID(UID_VAL),
    .CALIB_BITS(CAL_VAL)) u_dut (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .ERASE_PIN_I(pin),
    .IRQ_O(irq), .DEBUG_LOCK_O(dbg_lock));

  erase_pin_model u_pin (.clk_i(clk), .pin_o(pin));

  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask : chk_bit

  // One single-word AHB transfer; read data lands in rd
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsize  <= 3'b010;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  function automatic logic [31:0] ra(input logic [11:0] off);
    return {20'h0_0000, off};
  endfunction : ra

  task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
    chk_bit(hresp, 1'b0);
  endtask : rdc

  task automatic cmd(input logic [7:0] code, input logic [9:0] arg);
    xfer(ra(REG_CMD), 1'b1, {14'h0000, arg, code});
  endtask : cmd

  task automatic chk_fixed();
    rdc(ra(REG_CALIB), CAL_VAL);
    for (int k = 0; k < 4; k++) rdc(ra(REG_UID0) + 32'(4 * k), UID_VAL[32*k +: 32]);
  endtask : chk_fixed

  // Full pin erase takes 32768 cycles; ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    hsel   <= 1'b0;
    haddr  <= 32'h0000_0000;
    htrans <= 2'b00;
    hsize  <= 3'b000;
    hwrite <= 1'b0;
    hwdata <= 32'h0000_0000;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdc(ra(REG_STATUS), 32'h0000_0001);
    rdc(ra(REG_CONFIG), 32'h0000_0F01);
    rdc(ra(REG_LOCKS), 32'h0000_0000);
    rdc(ra(REG_GPNV), 32'h0000_0003);
    rdc(32'h0000_0FF0, 32'h0000_0000);
    chk_fixed();
    cmd(CMD_SET_LOCK, 10'h000);
    rdc(ra(REG_LOCKS), 32'h0000_0001);
    foreach (LOCKED_CMDS[k]) begin
      cmd(LOCKED_CMDS[k], 10'h000);
      repeat (3) @(posedge clk);
      chk_bit(irq, 1'b1);
      rdc(ra(REG_STATUS), 32'h0000_0005);
      repeat (3) @(posedge clk);
      chk_bit(irq, 1'b0);
    end
    cmd(CMD_CLR_LOCK, 10'h000);
    rdc(ra(REG_LOCKS), 32'h0000_0000);
    cmd(CMD_ERASE_PG, 10'h000);
    repeat (80) @(posedge clk);
    rdc(ra(REG_STATUS), 32'h0000_0001);
    cmd(CMD_SET_LOCK, 10'h007);
    rdc(ra(REG_LOCKS), 32'h0000_0080);
    cmd(CMD_GET_DESC, 10'h000);
    for (int k = 0; k < 7; k++) rdc(ra(REG_RESULT), DESC_EXP[k]);
    cmd(CMD_SET_GPNV, 10'h000);
    repeat (3) @(posedge clk);
    chk_bit(dbg_lock, 1'b1);
    cmd(CMD_CLR_GPNV, 10'h000);
    rdc(ra(REG_STATUS), 32'h0000_000B);
    rdc(ra(REG_GPNV), 32'h0000_0002);
    chk_bit(dbg_lock, 1'b1);
    // Pin as general I/O, also with the narrow read width
    xfer(ra(REG_CONFIG), 1'b1, 32'h0000_1F00);
    rdc(ra(REG_CONFIG), 32'h0000_1F00);
    u_pin.drive(40);
    repeat (4) @(posedge clk);
    rdc(ra(REG_STATUS), 32'h0000_0009);
    xfer(ra(REG_CONFIG), 1'b1, 32'h0000_0F01);
    u_pin.drive(8);
    repeat (4) @(posedge clk);
    rdc(ra(REG_STATUS), 32'h0000_0009);
    u_pin.drive(40);
    rdc(ra(REG_LOCKS), 32'h0000_0080);
    chk_bit(dbg_lock, 1'b1);
    n = 0;
    do begin
      xfer(ra(REG_STATUS), 1'b0, 32'h0000_0000);
      n++;
    end while (rd[ST_READY] !== 1'b1 && n < 20000);
    repeat (4) @(posedge clk);
    rdc(ra(REG_STATUS), 32'h0000_0001);
    rdc(ra(REG_LOCKS), 32'h0000_0000);
    rdc(ra(REG_GPNV), 32'h0000_0003);
    chk_bit(dbg_lock, 1'b0);
    rdc(32'h0002_0000, 32'hFFFF_FFFF);
    rdc(32'h0003_FFFC, 32'hFFFF_FFFF);
    chk_fixed();
    // Other buffer words are still zero, so they clear their cells
    xfer(32'h0000_0080, 1'b1, 32'h1234_5678);
    rdc(32'h0000_0080, 32'h1234_5678);
    cmd(CMD_PROG, 10'h000);
    rdc(32'h0002_0000, 32'h1234_5678);
    rdc(32'h0002_0004, 32'h0000_0000);
    end_sim();
  end
endmodule : flash_protect_erase_logic_tb
